// >>> phy_link_cfg_pkg.sv
/*
  package for the physical-layer link control register bank: offsets,
  field positions, reset values and timing counts.
  assumes a 250 MHz core clock and a 12-bit configuration dword address.
*/
package phy_link_cfg_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] PHY_LINK_CONFIGURATION_OFS  = 12'h530;
  localparam logic [11:0] PHY_LINK_STATE_CONTROL_OFS  = 12'h540;
  localparam logic [11:0] CROSSLINK_SEQUENCE_SEED_OFS = 12'h55C;

  localparam int unsigned COMPAT_BIT      = 8;
  localparam int unsigned XLINK_DIS_BIT   = 11;
  localparam int unsigned SPEED_CTRL_BIT  = 14;
  localparam int unsigned RETRAIN_BIT     = 31;
  localparam int unsigned SEED_W          = 16;

  localparam logic        SPEED_CTRL_RST_DOWNSTREAM = 1'h0;
  localparam logic        SPEED_CTRL_RST_OTHER      = 1'h1;
  localparam logic [15:0] SEED_RST                  = 16'hFFFF;

  // upstream retrain delay
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned RETRAIN_DELAY_US = 1000;
  localparam int unsigned RETRAIN_DELAY_CYC = RETRAIN_DELAY_US * CLK_MHZ;
  localparam int unsigned DELAY_W          = 18;

  // prbs feedback taps x^16 + x^5 + x^4 + x^3 + 1
  localparam logic [15:0] PRBS_TAPS = 16'h0039;

endpackage

// >>> seq_prbs_gen.sv
/*
  16-bit prbs generator used for crosslink operation.
  assumes load and advance come from logic on the same clock.
*/
module seq_prbs_gen (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] seed,
  input  wire logic        advance,
  output logic      [15:0] state
);

  typedef struct packed {
    logic [15:0] lfsr;
  } prbs_state_t;

  prbs_state_t s_reg;
  prbs_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.lfsr = seed;
    end else if (advance) begin
      s_next.lfsr = {s_reg.lfsr[14:0], ^(s_reg.lfsr & phy_link_cfg_pkg::PRBS_TAPS)};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg.lfsr <= phy_link_cfg_pkg::SEED_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign state = s_reg.lfsr;

endmodule

// >>> phy_link_config_regs.sv
/*
  per-port physical-layer link control registers: compatibility mode,
  crosslink disable, initial speed change control, full retrain command
  and crosslink prbs seed.
  assumes a single-cycle register port on sys_clk, a completion
  acknowledge from the request layer, and strap/status inputs from
  logic on the same clock.
*/
// What this block does
// - compat bit set forces gen1 mode and clears undefined training-set bits.
// - crosslink-disable bit set makes training behave as if no crosslink.
// - speed control 0 requests gen2 change after first L0 from Detect, when gen2_permitted is set.
// - speed control 1 never self-starts speed change; stay at gen1.
// - speed control resets to 0 on downstream port, 1 otherwise.
// - writing 1 to retrain bit forces the training machine to Detect.
// - retrain bit always reads back zero.
// - write completion is sent before retrain takes effect.
// - upstream port applies retrain only 1 ms after the write.
// - 16-bit crosslink prbs seed, resets to all ones.
// - changing the seed reloads the prbs counter from the new seed.
module phy_link_config_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        port_is_downstream,
  input  wire logic        port_is_upstream,
  input  wire logic        cpl_sent,
  input  wire logic        ltssm_in_detect,
  input  wire logic        ltssm_in_l0,
  input  wire logic        gen2_permitted,
  input  wire logic        prbs_advance,
  output logic             gen1_compat_mode,
  output logic             ts_undefined_bits_clear,
  output logic             crosslink_training_en,
  output logic             speed_change_req,
  output logic             retrain_detect_pulse,
  output logic      [15:0] prbs_state
);

  typedef enum logic [3:0] {
    RT_IDLE  = 4'h1,
    RT_CPL   = 4'h2,
    RT_DELAY = 4'h4,
    RT_FIRE  = 4'h8
  } retrain_state_t;

  typedef struct packed {
    logic             first_gen_compat_enable;
    logic             crosslink_training_disable;
    logic             initial_speed_change_ctrl;
    logic [15:0]      seed;
    logic             seed_load;
    retrain_state_t   rt;
    logic [17:0]      delay_cnt;
    logic             up_at_write;
    logic             seen_detect;
    logic             speed_done;
    logic             speed_req;
    logic             retrain_pulse;
    logic             strap_taken;
    logic [31:0]      rdata;
  } regs_state_t;

  regs_state_t s_reg;
  regs_state_t s_next;
  logic [15:0] prbs_q;

  always_comb begin
    s_next               = s_reg;
    s_next.seed_load     = 1'b0;
    s_next.retrain_pulse = 1'b0;
    s_next.speed_req     = 1'b0;
    s_next.rdata         = 32'h0000_0000;

    // speed control reset value follows the port operating mode
    if (!s_reg.strap_taken) begin
      s_next.strap_taken = 1'b1;
      s_next.initial_speed_change_ctrl = port_is_downstream ?
        phy_link_cfg_pkg::SPEED_CTRL_RST_DOWNSTREAM :
        phy_link_cfg_pkg::SPEED_CTRL_RST_OTHER;
    end

    if (reg_wr) begin
      case (reg_addr)
        phy_link_cfg_pkg::PHY_LINK_CONFIGURATION_OFS: begin
          s_next.first_gen_compat_enable =
            reg_wdata[phy_link_cfg_pkg::COMPAT_BIT];
          s_next.crosslink_training_disable =
            reg_wdata[phy_link_cfg_pkg::XLINK_DIS_BIT];
          s_next.initial_speed_change_ctrl =
            reg_wdata[phy_link_cfg_pkg::SPEED_CTRL_BIT];
        end
        phy_link_cfg_pkg::PHY_LINK_STATE_CONTROL_OFS: begin
          if (reg_wdata[phy_link_cfg_pkg::RETRAIN_BIT] && s_reg.rt == RT_IDLE) begin
            s_next.rt          = RT_CPL;
            s_next.up_at_write = port_is_upstream;
            s_next.delay_cnt   = 18'h00000;
          end
        end
        phy_link_cfg_pkg::CROSSLINK_SEQUENCE_SEED_OFS: begin
          if (reg_wdata[15:0] != s_reg.seed) begin
            s_next.seed_load = 1'b1;
          end
          s_next.seed = reg_wdata[15:0];
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        phy_link_cfg_pkg::PHY_LINK_CONFIGURATION_OFS: begin
          s_next.rdata[phy_link_cfg_pkg::COMPAT_BIT] = s_reg.first_gen_compat_enable;
          s_next.rdata[phy_link_cfg_pkg::XLINK_DIS_BIT] = s_reg.crosslink_training_disable;
          s_next.rdata[phy_link_cfg_pkg::SPEED_CTRL_BIT] = s_reg.initial_speed_change_ctrl;
        end
        phy_link_cfg_pkg::PHY_LINK_STATE_CONTROL_OFS: begin
          s_next.rdata = 32'h0000_0000;
        end
        phy_link_cfg_pkg::CROSSLINK_SEQUENCE_SEED_OFS: begin
          s_next.rdata[15:0] = s_reg.seed;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // retrain sequencing: completion first, then upstream delay, then pulse
    case (s_reg.rt)
      RT_IDLE: begin
      end
      RT_CPL: begin
        if (s_reg.up_at_write) begin
          s_next.delay_cnt = s_reg.delay_cnt + 18'h00001;
        end
        if (cpl_sent) begin
          s_next.rt = s_reg.up_at_write ? RT_DELAY : RT_FIRE;
        end
      end
      RT_DELAY: begin
        s_next.delay_cnt = s_reg.delay_cnt + 18'h00001;
        if (s_reg.delay_cnt >= 18'(phy_link_cfg_pkg::RETRAIN_DELAY_CYC - 1)) begin
          s_next.rt = RT_FIRE;
        end
      end
      RT_FIRE: begin
        s_next.retrain_pulse = 1'b1;
        s_next.rt            = RT_IDLE;
        s_next.seen_detect   = 1'b0;
        s_next.speed_done    = 1'b0;
      end
      default: begin
        s_next.rt = RT_IDLE;
      end
    endcase

    // automatic gen2 change once per L0 entry from Detect
    if (ltssm_in_detect) begin
      s_next.seen_detect = 1'b1;
      s_next.speed_done  = 1'b0;
    end
    if (ltssm_in_l0 && s_reg.seen_detect && !s_reg.speed_done) begin
      s_next.speed_done = 1'b1;
      s_next.seen_detect = 1'b0;
      if (!s_reg.initial_speed_change_ctrl && gen2_permitted) begin
        s_next.speed_req = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_reg.first_gen_compat_enable    <= 1'b0;
      s_reg.crosslink_training_disable <= 1'b0;
      s_reg.initial_speed_change_ctrl  <= phy_link_cfg_pkg::SPEED_CTRL_RST_OTHER;
      s_reg.seed                       <= phy_link_cfg_pkg::SEED_RST;
      s_reg.seed_load                  <= 1'b0;
      s_reg.rt                         <= RT_IDLE;
      s_reg.delay_cnt                  <= 18'h00000;
      s_reg.up_at_write                <= 1'b0;
      s_reg.seen_detect                <= 1'b0;
      s_reg.speed_done                 <= 1'b0;
      s_reg.speed_req                  <= 1'b0;
      s_reg.retrain_pulse              <= 1'b0;
      s_reg.strap_taken                <= 1'b0;
      s_reg.rdata                      <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  seq_prbs_gen u_prbs (
    .sys_clk (sys_clk),
    .rst     (rst),
    .load    (s_reg.seed_load),
    .seed    (s_reg.seed),
    .advance (prbs_advance),
    .state   (prbs_q)
  );

  assign reg_rdata               = s_reg.rdata;
  assign gen1_compat_mode        = s_reg.first_gen_compat_enable;
  assign ts_undefined_bits_clear = s_reg.first_gen_compat_enable;
  assign crosslink_training_en   = ~s_reg.crosslink_training_disable;
  assign speed_change_req        = s_reg.speed_req;
  assign retrain_detect_pulse    = s_reg.retrain_pulse;
  assign prbs_state              = prbs_q;

endmodule

// >>> phy_link_cfg_props.sv
/*
  checker for phy_link_config_regs: compat outputs, retrain pulse, speed request, seed reload.
  assumes one bound instance; pending retrains are tracked here to judge
  completion order and the upstream delay.
*/
module phy_link_cfg_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        port_is_upstream,
  input wire logic        cpl_sent,
  input wire logic        ltssm_in_l0,
  input wire logic        gen2_permitted,
  input wire logic        gen1_compat_mode,
  input wire logic        ts_undefined_bits_clear,
  input wire logic        crosslink_training_en,
  input wire logic        speed_change_req,
  input wire logic        retrain_detect_pulse,
  input wire logic [15:0] prbs_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic        seed_wr;
  logic [15:0] seed_reg;
  logic        retrain_wr;
  logic        rt_pend;
  logic        rt_up;
  logic        cpl_seen;
  logic [17:0] rt_cnt;
  localparam logic [17:0] UP_DELAY = 18'(phy_link_cfg_pkg::RETRAIN_DELAY_CYC);
  assign seed_wr = reg_wr && reg_addr == phy_link_cfg_pkg::CROSSLINK_SEQUENCE_SEED_OFS;
  assign retrain_wr = reg_wr && reg_addr == phy_link_cfg_pkg::PHY_LINK_STATE_CONTROL_OFS &&
    reg_wdata[phy_link_cfg_pkg::RETRAIN_BIT];
  // a retrain write is taken only while none is pending, or as the pulse leaves
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rt_pend  <= 1'b0;
      rt_up    <= 1'b0;
      cpl_seen <= 1'b0;
      rt_cnt   <= 18'h00000;
    end else begin
      if (retrain_detect_pulse) begin
        rt_pend  <= 1'b0;
        cpl_seen <= 1'b0;
      end else if (rt_pend && cpl_sent) begin
        cpl_seen <= 1'b1;
      end
      if (retrain_wr && (!rt_pend || retrain_detect_pulse)) begin
        rt_pend <= 1'b1;
        rt_up   <= port_is_upstream;
        rt_cnt  <= 18'h00000;
      end else if (rt_cnt != 18'h3FFFF) begin
        rt_cnt <= rt_cnt + 18'h00001;
      end
    end
  end
  // shadow of the stored seed, reload happens only on a changed value
  always_ff @(posedge sys_clk) begin
    if (rst) seed_reg <= phy_link_cfg_pkg::SEED_RST;
    else if (seed_wr) seed_reg <= reg_wdata[15:0];
  end
  compat_pair_a: assert property (gen1_compat_mode == ts_undefined_bits_clear)
    else $error("compat outputs differ");
  xlink_cause_a: assert property ($changed(crosslink_training_en) |->
    $past(reg_wr) || $past(reg_wr, 2)) else $error("crosslink enable moved without write");
  speed_cause_a: assert property (speed_change_req |->
    $past(ltssm_in_l0) && $past(gen2_permitted)) else $error("speed request without cause");
  speed_single_a: assert property (speed_change_req |=> !speed_change_req)
    else $error("speed request too long");
  state_rd_zero_a: assert property (reg_rd && reg_addr ==
    phy_link_cfg_pkg::PHY_LINK_STATE_CONTROL_OFS |=> reg_rdata == 32'h0)
    else $error("retrain register read not zero");
  pulse_cpl_a: assert property (retrain_detect_pulse |-> cpl_seen)
    else $error("retrain pulse before completion");
  up_delay_a: assert property (retrain_detect_pulse && rt_up |-> rt_cnt >= UP_DELAY)
    else $error("upstream retrain pulse too early");
  pulse_single_a: assert property (retrain_detect_pulse |=> !retrain_detect_pulse)
    else $error("retrain pulse too long");
  seed_reset_a: assert property (disable iff (1'b0) rst |=> prbs_state == 16'hFFFF)
    else $error("prbs not at seed reset value");
  seed_load_a: assert property (seed_wr && reg_wdata[15:0] != seed_reg |=>
    ##1 prbs_state == $past(reg_wdata[15:0], 2)) else $error("prbs not reloaded");
  cover property (retrain_detect_pulse);
  cover property (speed_change_req);
  cover property (seed_wr && reg_wdata[15:0] != seed_reg);
  cover property (retrain_wr && port_is_upstream);
endmodule

bind phy_link_config_regs phy_link_cfg_props u_props (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .port_is_upstream, .cpl_sent, .ltssm_in_l0, .gen2_permitted,
  .gen1_compat_mode,
  .ts_undefined_bits_clear, .crosslink_training_en, .speed_change_req, .retrain_detect_pulse,
  .prbs_state);

// >>> tb_top.sv
/*
  self-checking bench for phy_link_config_regs.
  assumes the bench alone drives the register port and the link status inputs.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, cpl_sent = 0, prbs_advance = 0;
  logic        port_is_downstream = 1, port_is_upstream = 0, gen2_permitted = 0;
  logic        ltssm_in_detect = 0, ltssm_in_l0 = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        gen1_compat_mode, ts_undefined_bits_clear, crosslink_training_en;
  logic        speed_change_req, retrain_detect_pulse;
  logic [15:0] prbs_state;
  int          failures = 0, n_checks = 0, c;
  phy_link_config_regs uut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_is_downstream, .port_is_upstream, .cpl_sent, .ltssm_in_detect, .ltssm_in_l0,
    .gen2_permitted, .prbs_advance, .gen1_compat_mode, .ts_undefined_bits_clear,
    .crosslink_training_en, .speed_change_req, .retrain_detect_pulse, .prbs_state);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic wr(logic [11:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
    @(posedge sys_clk);
  endtask
  // counts high samples of a pulse output over n cycles; an unknown counts heavily
  task automatic count_hi(logic pick_retrain, int n);
    logic s;
    c = 0;
    repeat (n) begin
      #1 s = pick_retrain ? retrain_detect_pulse : speed_change_req;
      c += (s === 1'b1) ? 1 : ((s === 1'b0) ? 0 : 1000);
      @(posedge sys_clk);
    end
  endtask
  task automatic do_reset(logic down);
    rst <= 1'b1;
    port_is_downstream <= down;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic s_config;
    wr(12'h530, 32'hFFFFFFFF);
    rd(12'h530, 32'h00004900);
    `CHK("compat", 1'b1, gen1_compat_mode)
    `CHK("ts_clear", 1'b1, ts_undefined_bits_clear)
    `CHK("xlink_en", 1'b0, crosslink_training_en)
    wr(12'h530, 32'h0);
    @(posedge sys_clk);
    wr(12'h600, 32'hFFFFFFFF);
    rd(12'h600, 32'h0);
    rd(12'h530, 32'h0);
    `CHK("xlink_en", 1'b1, crosslink_training_en)
  endtask
  task automatic s_retrain(logic up, int n, int e);
    port_is_upstream <= up;
    wr(12'h540, 32'h80000000);
    rd(12'h540, 32'h0);
    count_hi(1'b1, 6);
    `CHK("early pulse", 0, c)
    cpl_sent <= 1'b1;
    @(posedge sys_clk);
    cpl_sent <= 1'b0;
    count_hi(1'b1, n);
    `CHK("retrain pulses", e, c)
  endtask
  task automatic s_seed;
    wr(12'h55C, 32'h00001234);
    rd(12'h55C, 32'h00001234);
    #1 `CHK("prbs load", 16'h1234, prbs_state)
    @(posedge sys_clk);
    prbs_advance <= 1'b1;
    @(posedge sys_clk);
    prbs_advance <= 1'b0;
    #1 `CHK("prbs runs", 1'b1, prbs_state !== 16'h1234)
    @(posedge sys_clk);
  endtask
  task automatic s_speed(logic g2, int e);
    gen2_permitted <= g2;
    ltssm_in_detect <= 1'b1;
    @(posedge sys_clk);
    ltssm_in_detect <= 1'b0;
    ltssm_in_l0 <= 1'b1;
    count_hi(1'b0, 6);
    ltssm_in_l0 <= 1'b0;
    `CHK("speed requests", e, c)
  endtask
  task automatic give_verdict;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    rd(12'h530, 32'h0);
    rd(12'h55C, 32'h0000FFFF);
    `CHK("prbs reset", 16'hFFFF, prbs_state)
    s_config();
    s_retrain(1'b0, 6, 1);
    s_seed();
    s_speed(1'b0, 0);
    s_speed(1'b1, 1);
    do_reset(1'b0);
    rd(12'h530, 32'h00004000);
    s_speed(1'b1, 0);
    s_retrain(1'b1, 2000, 0);
    give_verdict();
  end
endmodule
